// ==== rtl/emi_ext_mem_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// Function
// - Pins are claimed only during an off-chip move, then returned to latches.
// - Data pin drivers are switched off while the data lines are inputs.
// - The block enables all data drivers except in the data phase of reads; port mode decides output mode.
// - Under latch control the output mode stays as the mode registers set.
// - Multiplexed mode shares low address and data on one bidirectional bus.
// - Banked or 16-bit moves drive upper address pins; non-banked leaves them.
// - Multiplexed access: strobe high with address, then falls, then data.
// - Mode 00 sends every access to on-chip memory.
// - Internal-only addresses wrap over the on-chip memory size.
// - 8-bit moves use page and index; 16-bit moves use the data pointer.
// - Mode 01 splits on-chip below the boundary, off-chip above.
// - Non-banked split 8-bit off-chip moves leave upper pins undriven.
// - Split 16-bit moves decide by data pointer and drive twelve pins.
// - Mode 10 8-bit moves drive upper bits from the page register.
// - Mode 11 sends every access off-chip; on-chip memory invisible.
// - External-only 8-bit ignores page, upper pins free; 16-bit drives twelve.
// - Setup, hold, strobe and address-strobe widths programmable in cycles.
// - Off-chip access lasts programmed timing plus five cycles, minimum five.
// - Multiplexed mode adds at least two address-strobe cycles, minimum seven.
// - Timing settings reset to their maximum delay values.
// - Split-mode 8-bit moves go off-chip when page select MSB is one.
// - On-chip memory is 4096 bytes and sets the split boundary.
module emi_ext_mem_if #(
    parameter int XRAM_BYTES = emi_pkg::XRAM_BYTES
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rstn,
    // Registers written by software.
    input wire logic [7:0] xram_page_register,
    input wire logic [7:0] memory_config_register,
    input wire logic [7:0] memory_timing_register,
    input wire logic cfg_we,
    input wire logic multiplexed,
    // Core request and answer.
    input wire logic req_valid,
    input wire emi_pkg::emi_req_t req,
    output logic req_ready,
    output logic done,
    output logic [7:0] rdata,
    output logic busy_offchip,
    // Port latch values, used while the pins are parked, and output mode, used in every state.
    input wire logic [11:0] latch_addr,
    input wire logic [7:0] latch_data,
    input wire logic latch_ale,
    input wire logic latch_rd_n,
    input wire logic latch_wr_n,
    input wire logic [22:0] port_output_mode_regs,
    // Off-chip pins.
    output logic [11:8] addr_hi_out,
    output logic [7:0] ad_out,
    output logic [7:0] ad_oe,
    input wire logic [7:0] ad_in,
    output logic [7:0] addr_lo_out,
    output logic ale,
    output logic rd_n,
    output logic wr_n,
    output logic [22:0] pin_push_pull
);

    localparam int AW = $clog2(XRAM_BYTES);

    logic [7:0] cfg;
    logic [7:0] tc;
    logic [7:0] page;
    emi_pkg::emi_state_t state;
    emi_pkg::emi_state_t next_state;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic [7:0] xram [XRAM_BYTES];
    logic [15:0] eff;
    logic [15:0] eff_q;
    logic hi_drive;
    logic wr_q;
    logic mux_q;
    logic [7:0] wdata_q;

    // Timing register and configuration load; reset gives maximum delays.
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cfg <= emi_pkg::CFG_RESET;
            tc <= emi_pkg::TC_RESET;
            page <= emi_pkg::PAGE_RESET;
        end
        else if (cfg_we)
        begin
            cfg <= memory_config_register;
            tc <= memory_timing_register;
            page <= xram_page_register;
        end
    end

    wire [1:0] mode = cfg[emi_pkg::CFG_MODE_LSB +: 2];
    wire [1:0] ale_w = cfg[emi_pkg::CFG_ALE_LSB +: 2];
    wire [1:0] setup_w = tc[emi_pkg::TC_SETUP_LSB +: 2];
    wire [3:0] strobe_w = tc[emi_pkg::TC_WIDTH_LSB +: 4];
    wire [1:0] hold_w = tc[emi_pkg::TC_HOLD_LSB +: 2];

    // Effective address: page and index, or the full data pointer.
    assign eff = req.wide ? req.data_pointer_pair : {page, req.index};
    wire split = (mode == emi_pkg::MODE_SPLIT_NOBANK) || (mode == emi_pkg::MODE_SPLIT_BANK);
    wire above = req.wide ? (req.data_pointer_pair >= 16'(XRAM_BYTES))
                          : page[emi_pkg::PAGE_MSB];
    wire offchip = (mode == emi_pkg::MODE_EXT_ONLY)
                 || (split && above);
    wire hi_req = req.wide || (mode == emi_pkg::MODE_SPLIT_BANK);

    wire idle = (state == emi_pkg::EMI_IDLE);
    assign req_ready = idle;
    wire take = req_valid && idle;
    wire [AW-1:0] xaddr = eff[AW-1:0];

    // On-chip memory: one-cycle access, never touches the pins.
    always_ff @(posedge ref_clk)
    begin
        if (take && !offchip && req.write)
            xram[xaddr] <= req.wdata;
    end

    always_comb
    begin
        next_state = state;
        next_cnt = cnt - 4'h1;
        unique case (state)
            emi_pkg::EMI_IDLE:
            begin
                next_cnt = 4'h0;
                if (take && offchip)
                begin
                    next_state = multiplexed ? emi_pkg::EMI_ALE : emi_pkg::EMI_SETUP;
                    next_cnt = multiplexed ? emi_pkg::ALE_MIN + 4'(ale_w) - 4'h1
                                           : 4'(setup_w);
                end
            end
            emi_pkg::EMI_ALE:
                if (cnt == 4'h0)
                begin
                    next_state = emi_pkg::EMI_SETUP;
                    next_cnt = 4'(setup_w);
                end
            emi_pkg::EMI_SETUP:
                if (cnt == 4'h0)
                begin
                    next_state = emi_pkg::EMI_STROBE;
                    next_cnt = strobe_w;
                end
            emi_pkg::EMI_STROBE:
                if (cnt == 4'h0)
                begin
                    next_state = emi_pkg::EMI_HOLD;
                    next_cnt = 4'(hold_w);
                end
            emi_pkg::EMI_HOLD:
                if (cnt == 4'h0)
                begin
                    next_state = emi_pkg::EMI_TAIL;
                    // Setup, strobe and hold each spend one cycle beyond their field value,
                    // so the tail carries only what is left of the fixed overhead.
                    next_cnt = emi_pkg::FIXED_CYCLES - 4'h3;
                end
            emi_pkg::EMI_TAIL:
                if (cnt == 4'h0)
                    next_state = emi_pkg::EMI_IDLE;
            default:
                next_state = emi_pkg::EMI_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= emi_pkg::EMI_IDLE;
            cnt <= 4'h0;
            eff_q <= 16'h0000;
            hi_drive <= 1'b0;
            wr_q <= 1'b0;
            mux_q <= 1'b0;
            wdata_q <= 8'h00;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            if (take)
            begin
                eff_q <= eff;
                hi_drive <= hi_req;
                wr_q <= req.write;
                mux_q <= multiplexed;
                wdata_q <= req.wdata;
            end
        end
    end

    // Read data and completion.
    wire strobe_end = (state == emi_pkg::EMI_STROBE) && (cnt == 4'h0);
    wire tail_end = (state == emi_pkg::EMI_TAIL) && (cnt == 4'h0);
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rdata <= 8'h00;
            done <= 1'b0;
        end
        else
        begin
            done <= (take && !offchip) || tail_end;
            if (take && !offchip && !req.write)
                rdata <= xram[xaddr];
            else if (strobe_end && !wr_q)
                rdata <= ad_in;
        end
    end

    // Pin ownership: only while an off-chip access runs.
    wire own = !idle;
    assign busy_offchip = own;
    wire in_strobe = (state == emi_pkg::EMI_STROBE);
    wire in_ale = (state == emi_pkg::EMI_ALE);
    wire data_phase = !mux_q || !in_ale;

    assign ale = own ? (mux_q && in_ale) : latch_ale;
    assign rd_n = own ? !(in_strobe && !wr_q) : latch_rd_n;
    assign wr_n = own ? !(in_strobe && wr_q) : latch_wr_n;
    assign addr_hi_out = (own && hi_drive) ? eff_q[11:8] : latch_addr[11:8];
    assign addr_lo_out = own ? eff_q[7:0] : latch_addr[7:0];
    // Shared bus carries the address in the address-strobe phase, data afterwards.
    assign ad_out = !own ? latch_data
                  : (mux_q && !data_phase) ? eff_q[7:0] : wdata_q;
    // Drivers stay off while the bus is an input; all eight are enabled otherwise.
    assign ad_oe = (own && !wr_q && data_phase) ? 8'h00 : 8'hFF;
    // Output mode comes from the mode registers in every state.
    assign pin_push_pull = port_output_mode_regs;

    chk_one_strobe: assert property (@(posedge ref_clk) disable iff (!rstn)
        !(!rd_n && !wr_n && own)) else $error("both strobes asserted");
    chk_read_drivers_off: assert property (@(posedge ref_clk) disable iff (!rstn)
        (own && !rd_n) |-> (ad_oe == 8'h00)) else $error("drivers on during read");
    chk_ale_before_rd: assert property (@(posedge ref_clk) disable iff (!rstn)
        (idle && take && offchip && multiplexed) |=> ale [*2]) else $error("ale short");
    chk_min_nonmux: assert property (@(posedge ref_clk) disable iff (!rstn)
        (take && offchip && !multiplexed) |=> own [*4]) else $error("access too short");
    chk_min_mux: assert property (@(posedge ref_clk) disable iff (!rstn)
        (take && offchip && multiplexed) |=> own [*6]) else $error("mux access short");
    chk_done_bound: assert property (@(posedge ref_clk) disable iff (!rstn)
        (take && offchip) |=> ##[1:40] done) else $error("access never done");
    chk_int_only: assert property (@(posedge ref_clk) disable iff (!rstn)
        (take && mode == emi_pkg::MODE_INT_ONLY) |=> !own) else $error("went off-chip");
    chk_ext_only: assert property (@(posedge ref_clk) disable iff (!rstn)
        (take && mode == emi_pkg::MODE_EXT_ONLY) |=> own) else $error("stayed on-chip");
    chk_hi_free: assert property (@(posedge ref_clk) disable iff (!rstn)
        (own && !hi_drive) |-> (addr_hi_out == latch_addr[11:8])) else $error("hi driven");
    chk_release: assert property (@(posedge ref_clk) disable iff (!rstn)
        $fell(own) |-> done) else $error("pins released without completion");
    chk_tail_release: assert property (@(posedge ref_clk) disable iff (!rstn)
        tail_end |=> !own) else $error("pins held after access");
    chk_ale_no_strobe: assert property (@(posedge ref_clk) disable iff (!rstn)
        (own && ale) |-> (rd_n && wr_n)) else $error("strobe during address phase");
    chk_parked_pins: assert property (@(posedge ref_clk) disable iff (!rstn)
        !own |-> (ad_oe == 8'hFF)) else $error("drivers changed while parked");

endmodule : emi_ext_mem_if
`default_nettype wire

// ==== rtl/emi_pkg.sv ====
package emi_pkg;

    // Mode select field encodings.
    localparam logic [1:0] MODE_INT_ONLY = 2'h0;
    localparam logic [1:0] MODE_SPLIT_NOBANK = 2'h1;
    localparam logic [1:0] MODE_SPLIT_BANK = 2'h2;
    localparam logic [1:0] MODE_EXT_ONLY = 2'h3;

    // Field positions in the configuration register.
    localparam int CFG_MODE_LSB = 2;
    localparam int CFG_ALE_LSB = 0;

    // Field positions in the timing register.
    localparam int TC_SETUP_LSB = 6;
    localparam int TC_WIDTH_LSB = 2;
    localparam int TC_HOLD_LSB = 0;

    // Reset values: all setup, hold and strobe widths at their maximum.
    localparam logic [7:0] CFG_RESET = 8'h03;
    localparam logic [7:0] TC_RESET = 8'hFF;
    localparam logic [7:0] PAGE_RESET = 8'h00;

    // Page select field MSB and on-chip size.
    localparam int PAGE_MSB = 4;
    localparam int XRAM_BYTES = 4096;
    localparam int XRAM_AW = 12;

    // Fixed overhead base; an access adds one cycle more than this to the programmed timing.
    localparam logic [3:0] FIXED_CYCLES = 4'h4;
    localparam logic [3:0] ALE_MIN = 4'h2;

    typedef enum logic [2:0] {
        EMI_IDLE = 3'b000,
        EMI_ALE = 3'b001,
        EMI_SETUP = 3'b010,
        EMI_STROBE = 3'b011,
        EMI_HOLD = 3'b100,
        EMI_TAIL = 3'b101
    } emi_state_t;

    typedef struct packed {
        logic wide;
        logic write;
        logic [15:0] data_pointer_pair;
        logic [7:0] index;
        logic [7:0] wdata;
    } emi_req_t;

endpackage : emi_pkg

// ==== verification/emi_sram_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module emi_sram_model (
    // Clock.
    input wire logic ref_clk,
    // Memory pins as the far side sees them.
    input wire logic [11:8] addr_hi,
    input wire logic [7:0] addr_lo,
    input wire logic [7:0] ad_out,
    input wire logic ale,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic mux,
    output logic [7:0] ad_in
);
    logic [7:0] mem [4096];
    logic [7:0] alat = 8'h00;
    logic [7:0] last = 8'h00;
    wire logic [11:0] a = {addr_hi, mux ? alat : addr_lo};
    // A released bus shows the inverse of the last read, so stale data never looks valid.
    assign ad_in = rd_n ? ~last : mem[a];
    always @(posedge ref_clk)
    begin
        if (ale)
            alat <= ad_out;
        if (!rd_n)
            last <= mem[a];
        if (!wr_n)
            mem[a] <= ad_out;
    end
endmodule : emi_sram_model
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] pg = 8'h00, cf = 8'h03, tm = 8'hFF, rdata, ad_out, ad_oe, ad_in, addr_lo, rd;
    logic cfg_we = 1'b0, mux = 1'b0, req_valid = 1'b0;
    logic req_ready, done, busy, ale, rd_n, wr_n;
    logic [11:8] addr_hi;
    logic [22:0] ppm = 23'h2AAAAA, ppo;
    emi_pkg::emi_req_t req = '0;
    int bad_count = 0;
    int check_count = 0;
    int n;
    always #5 ref_clk = ~ref_clk;
    emi_ext_mem_if emi_ext_mem_if_i (.ref_clk(ref_clk), .rstn(rstn),
        .xram_page_register(pg), .memory_config_register(cf),
        .memory_timing_register(tm), .cfg_we(cfg_we), .multiplexed(mux),
        .req_valid(req_valid), .req(req), .req_ready(req_ready), .done(done),
        .rdata(rdata), .busy_offchip(busy), .latch_addr(12'hFFF),
        .latch_data(8'hFF), .latch_ale(1'b1), .latch_rd_n(1'b1), .latch_wr_n(1'b1),
        .port_output_mode_regs(ppm), .addr_hi_out(addr_hi), .ad_out(ad_out),
        .ad_oe(ad_oe), .ad_in(ad_in), .addr_lo_out(addr_lo), .ale(ale),
        .rd_n(rd_n), .wr_n(wr_n), .pin_push_pull(ppo));
    emi_sram_model emi_sram_model_i (.ref_clk(ref_clk), .addr_hi(addr_hi),
        .addr_lo(addr_lo), .ad_out(ad_out), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
        .mux(mux), .ad_in(ad_in));
    task chk(input string nm, input logic [22:0] seen, input logic [22:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task complete_run;
        $display("Checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run
    task setc(input logic [7:0] p, input logic [1:0] md, input logic [1:0] ax,
              input logic [7:0] t, input logic m);
        @(negedge ref_clk);
        pg = p;
        cf = {4'h0, md, ax};
        tm = t;
        mux = m;
        cfg_we = 1'b1;
        @(negedge ref_clk);
        cfg_we = 1'b0;
    endtask : setc
    // Latency is counted in whole cycles from the edge that takes the request.
    task acc(input logic w, input logic wd, input logic [15:0] dp,
             input logic [7:0] ix, input logic [7:0] d, input int lat);
        @(negedge ref_clk);
        req = '{wd, w, dp, ix, d};
        req_valid = 1'b1;
        @(posedge ref_clk);
        @(negedge ref_clk);
        req_valid = 1'b0;
        n = 1;
        while (done !== 1'b1 && n < 100)
        begin
            @(negedge ref_clk);
            n++;
        end
        rd = rdata;
        chk("latency", 23'(n), 23'(lat));
    endtask : acc
    // Look a little after the falling edge so that stimulus applied there has settled.
    always @(negedge ref_clk)
    begin
        #1;
        if (rstn)
        begin
            chk("push pull", ppo, ppm);
            if (busy !== 1'b1)
                chk("parked", {addr_hi, ale, rd_n, wr_n, ad_oe}, 15'h7FFF);
            else
                chk("strobes", 23'(rd_n | wr_n), 23'h1);
            if (busy === 1'b1 && rd_n === 1'b0)
                chk("read oe", 23'(ad_oe), 23'h0);
        end
    end
    initial
    begin
        repeat (10) @(posedge ref_clk);
        chk("reset out", {done, rdata}, 23'h0);
        @(negedge ref_clk);
        rstn = 1'b1;
        ppm = 23'h155555;
        setc(8'h00, 2'h0, 2'h0, 8'h00, 1'b0);
        acc(1'b1, 1'b1, 16'h1005, 8'h00, 8'hA5, 1);
        acc(1'b0, 1'b0, 16'hFFFF, 8'h05, 8'h00, 1);
        chk("wrap", rd, 8'hA5);
        setc(8'h1F, 2'h3, 2'h0, 8'h00, 1'b0);
        acc(1'b1, 1'b1, 16'h0123, 8'h00, 8'h3C, 6);
        chk("ext wr", emi_sram_model_i.mem[12'h123], 8'h3C);
        acc(1'b0, 1'b1, 16'h0123, 8'h00, 8'h00, 6);
        chk("ext rd", rd, 8'h3C);
        acc(1'b1, 1'b0, 16'h0000, 8'h44, 8'h5A, 6);
        chk("ext 8b", emi_sram_model_i.mem[12'hF44], 8'h5A);
        setc(8'h05, 2'h1, 2'h0, 8'h00, 1'b0);
        acc(1'b1, 1'b0, 16'h0000, 8'h22, 8'h11, 1);
        setc(8'h15, 2'h1, 2'h0, 8'h00, 1'b0);
        acc(1'b1, 1'b0, 16'h0000, 8'h22, 8'h66, 6);
        chk("nobank", emi_sram_model_i.mem[12'hF22], 8'h66);
        acc(1'b1, 1'b1, 16'h1234, 8'h00, 8'h77, 6);
        chk("split 16b", emi_sram_model_i.mem[12'h234], 8'h77);
        acc(1'b0, 1'b1, 16'h0FFF, 8'h00, 8'h00, 1);
        setc(8'h1A, 2'h2, 2'h0, 8'h00, 1'b0);
        acc(1'b1, 1'b0, 16'h0000, 8'h33, 8'h99, 6);
        chk("bank", emi_sram_model_i.mem[12'hA33], 8'h99);
        // Setup 1, strobe 2, hold 1 and one extra address-strobe cycle.
        setc(8'h00, 2'h3, 2'h1, 8'h49, 1'b1);
        acc(1'b1, 1'b1, 16'h0456, 8'h00, 8'hC3, 13);
        chk("mux wr", emi_sram_model_i.mem[12'h456], 8'hC3);
        acc(1'b0, 1'b1, 16'h0456, 8'h00, 8'h00, 13);
        chk("mux rd", rd, 8'hC3);
        complete_run;
    end
    initial
    begin
        #20000;
        bad_count++;
        complete_run;
    end
endmodule : tb_top
`default_nettype wire
